// ---- verilog/bcs_sequencer.sv ----
`timescale 1ns/1ps
// Operation
// RL1: one of six states, cyclic order
// RL2: each state drives its phase pattern
// RL3: direction picks ascending or descending order
// RL4: run clear turns every gate off
// RL5: run with brake turns lowers on
// RL6: upper on is low, lower on high
// RL7: off is upper high, lower low
// RL8: speed source selectable, electrical cycle default
// RL9: cycle signal high at 1, low 4
// RL10: rate signal falls at each commutation
// RL11: speed output pulls low or releases
// RL12: fault output pulls low on fault
// RL13: sixteen bit words, msb first
// RL14: output released idle, fault bit first
// RL15: data sampled on serial clock rise
// RL16: host gives 16 edges, clock high
// RL17: strobe high ignores clock and data
// RL18: output bit changes after falling edge
// RL19: advance per pulse, load from startup
module bcs_sequencer
   import bcs_pkg::*;
#(
   parameter int PERIOD_BITS = PERIOD_W        // Commutation_rate_signal period counter
)(
   input  wire logic       sys_clk_in,            // System clock 25 MHz
   input  wire logic       nrst_in,               // Async reset, low
   input  wire logic       run_in,                // Run control
   input  wire logic       brake_control_in,      // Brake control
   input  wire logic       direction_in,          // 1 = descending
   input  wire logic       commutation_pulse_in,  // One-cycle pulse
   input  wire logic       load_in,               // Startup load strobe
   input  wire logic [5:0] load_state_in,         // One-hot load state
   input  wire logic       fault_flag_in,         // Fault indicated
   input  wire logic       serial_clk_in,         // Serial clock
   input  wire logic       serial_strobe_low_in,  // Strobe, active low
   input  wire logic       serial_data_in,        // Serial data in
   output logic            serial_data_out,       // Serial data value
   output logic            serial_data_oe_n_out,  // Low while driving
   output logic            upper_gate_a_out,      // Low = switch on
   output logic            upper_gate_b_out,      // Low = switch on
   output logic            upper_gate_c_out,      // Low = switch on
   output logic            lower_gate_a_out,      // High = switch on
   output logic            lower_gate_b_out,      // High = switch on
   output logic            lower_gate_c_out,      // High = switch on
   output logic            speed_output_out,      // Open-drain value
   output logic            speed_output_oe_n_out, // Low pulls pin low
   output logic            fault_output_low_out,  // Open-drain value
   output logic            fault_output_low_oe_n_out, // Low pulls low
   output logic [15:0]     config_word_out,       // Last serial word
   output logic [5:0]      state_out              // Sequencer state
);

   // ----------------------------------------------------------------
   // Serial port in its own domain
   // ----------------------------------------------------------------
   bcs_link_if link ();   // Crossing carrier

   bcs_serial_port u_port (
      .serial_clk_in        (serial_clk_in),
      .nrst_in              (nrst_in),
      .serial_strobe_low_in (serial_strobe_low_in),
      .serial_data_in       (serial_data_in),
      .serial_data_out      (serial_data_out),
      .serial_data_oe_n_out (serial_data_oe_n_out),
      .link                 (link.port)
   );

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bcs_state_e             state;          // Current drive state
   bcs_state_e             next_state;     // State after this edge
   logic [5:0]             gates;          // {upper C..A, lower C..A}
   logic                   ecycle;         // Electrical cycle signal
   logic                   commutation_rate_signal;          // Commutation rate signal
   logic [PERIOD_BITS-1:0] period_count;   // Cycles since commutation
   logic [PERIOD_BITS-1:0] half_period;    // Half of last period
   logic                   speed_oe_n;     // Registered speed drive
   logic                   fault_oe_n;     // Registered fault drive
   logic                   strobe_meta;    // Strobe sync stage 1
   logic                   strobe_sync;    // Strobe sync stage 2
   logic                   tgl_meta;       // Word toggle stage 1
   logic                   tgl_sync;       // Word toggle stage 2
   logic                   tgl_seen;       // Toggle already consumed
   logic [15:0]            diag_hold;      // Diagnostic word to send

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   wire        running   = run_in & ~brake_control_in;  // Run mode
   wire        advance   = running & commutation_pulse_in;
   wire        new_word  = tgl_sync ^ tgl_seen;         // Word arrived
   wire        speed_sel = config_word_out[CFG_SEL];    // 1 = commutation_rate_signal
   wire [5:0]  run_drive = bcs_drive(next_state);
   wire [PERIOD_BITS-1:0] period_next =
      (&period_count) ? period_count : period_count + 1'b1;
   wire [15:0] diag_live = {fault_flag_in, state, run_in,
                            brake_control_in, direction_in, speed_sel,
                            5'h00};

   // Load wins over a commutation pulse in the same cycle; an
   // invalid load code falls back to state 1
   // RL19: pulse advance, load
   // RL3: direction order
   always_comb begin
      next_state = state;
      if (load_in) begin
         next_state = $onehot(load_state_in) ?
                      bcs_state_e'(load_state_in) : ST_1;
      end else if (advance) begin
         next_state = bcs_step(state, direction_in);
      end
   end

   // RL4: coast all off
   // RL5: brake lowers on
   // RL2: state phase map
   assign gates = !run_in           ? 6'h00 :
                  brake_control_in  ? 6'h07 : run_drive;

   // ----------------------------------------------------------------
   // Sequencer and gate drive registers
   // ----------------------------------------------------------------
   // RL1: hold one state
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= ST_1;
      end else begin
         state <= next_state;
      end
   end

   // Gates are registered so the bridge never sees decode glitches
   // RL6: active levels
   // RL7: off levels
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {upper_gate_c_out, upper_gate_b_out, upper_gate_a_out} <= 3'h7;
         {lower_gate_c_out, lower_gate_b_out, lower_gate_a_out} <= 3'h0;
      end else begin
         {upper_gate_c_out, upper_gate_b_out, upper_gate_a_out}
            <= ~gates[5:3];
         {lower_gate_c_out, lower_gate_b_out, lower_gate_a_out}
            <= gates[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Speed signals
   // ----------------------------------------------------------------
   // Tracks the state entered on this edge, so it moves with the gates
   // RL9: cycle edges
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ecycle <= 1'b0;
      end else if (next_state != state && next_state == ST_1) begin
         ecycle <= 1'b1;
      end else if (next_state != state && next_state == ST_4) begin
         ecycle <= 1'b0;
      end
   end

   // Rises halfway through, using the previous period as estimate;
   // the counter saturates so a stalled motor leaves it high.
   // A load that swallows a pulse still restarts the period, since
   // the bridge pattern changes at that edge as well
   // RL10: falls at commutation
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         commutation_rate_signal        <= 1'b0;
         period_count <= '0;
         half_period  <= '0;
      end else if (advance) begin
         commutation_rate_signal        <= 1'b0;
         period_count <= '0;
         half_period  <= period_count >> 1;
      end else begin
         period_count <= period_next;
         if (period_count == half_period) begin
            commutation_rate_signal <= 1'b1;
         end
      end
   end

   // RL8: source select
   // RL11: open drain speed
   // RL12: open drain fault
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         speed_oe_n <= 1'b1;
         fault_oe_n <= 1'b1;
      end else begin
         speed_oe_n <= speed_sel ? commutation_rate_signal : ecycle;
         fault_oe_n <= ~fault_flag_in;
      end
   end

   assign speed_output_out          = 1'b0;
   assign speed_output_oe_n_out     = speed_oe_n;
   assign fault_output_low_out      = 1'b0;
   assign fault_output_low_oe_n_out = fault_oe_n;
   assign state_out                 = state;

   // ----------------------------------------------------------------
   // Serial crossings
   // ----------------------------------------------------------------
   // Strobe and word toggle each pass two flops before use
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         strobe_meta <= 1'b1;
         strobe_sync <= 1'b1;
         tgl_meta    <= 1'b0;
         tgl_sync    <= 1'b0;
      end else begin
         strobe_meta <= serial_strobe_low_in;
         strobe_sync <= strobe_meta;
         tgl_meta    <= link.rx_toggle;
         tgl_sync    <= tgl_meta;
      end
   end

   // Word is stable long before its toggle arrives here
   // RL13: take word
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tgl_seen        <= 1'b0;
         config_word_out <= CFG_RESET;
      end else if (new_word) begin
         tgl_seen        <= tgl_sync;
         config_word_out <= link.rx_word;
      end
   end

   // Frozen during a frame so the serial side reads a steady word;
   // a fault that starts mid-frame shows in the next frame
   // RL14: fault bit source
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         diag_hold <= 16'h0000;
      end else if (strobe_sync) begin
         diag_hold <= diag_live;
      end
   end

   assign link.diag_word = diag_hold;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // All checks here live in the system clock domain
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence commutate_s;
      advance && !load_in;
   endsequence

   sequence enter_one_s;
      state == ST_1 && $past(state) != ST_1;
   endsequence

   state_onehot_a: assert property ($onehot(state)) // RL1
      else $error("state not one-hot");

   step_order_a: assert property (commutate_s |=> // RL3
      state == bcs_step($past(state), $past(direction_in)))
      else $error("wrong step direction");

   state_hold_a: assert property (!advance && !load_in |=> // RL19
      $stable(state))
      else $error("state moved without a pulse");

   coast_off_a: assert property (!run_in |=> // RL4
      {upper_gate_c_out, upper_gate_b_out, upper_gate_a_out,
       lower_gate_c_out, lower_gate_b_out, lower_gate_a_out} == 6'h38)
      else $error("gates not off in coast");

   brake_low_a: assert property (run_in && brake_control_in |=> // RL5
      {upper_gate_c_out, upper_gate_b_out, upper_gate_a_out,
       lower_gate_c_out, lower_gate_b_out, lower_gate_a_out} == 6'h3F)
      else $error("brake pattern wrong");

   drive_map_a: assert property (running |=> // RL6
      {~upper_gate_c_out, ~upper_gate_b_out, ~upper_gate_a_out,
       lower_gate_c_out, lower_gate_b_out, lower_gate_a_out}
      == bcs_drive(state))
      else $error("gate levels do not match state");

   cycle_high_a: assert property (enter_one_s |-> ecycle) // RL9
      else $error("cycle signal low in state 1");

   commutation_rate_signal_fall_a: assert property (commutate_s |=> !commutation_rate_signal) // RL10
      else $error("rate signal not low after commutation");

   speed_src_a: assert property (!speed_sel && !ecycle |=> // RL8
      !speed_output_oe_n_out && !speed_output_out)
      else $error("speed output not following cycle signal");

   fault_pull_a: assert property (fault_flag_in |=> // RL12
      !fault_output_low_oe_n_out ##0 !fault_output_low_out)
      else $error("fault output not pulled low");

endmodule

// ---- verilog/bcs_pkg.sv ----
package bcs_pkg;

   // ----------------------------------------------------------------
   // Serial word layout
   // ----------------------------------------------------------------
   localparam int          WORD_BITS  = 16;        // Bits per transfer
   localparam logic [3:0]  LAST_BIT   = 4'hF;      // Index of last bit
   localparam int          FAULT_BIT  = 15;        // Fault flag position
   localparam int          STATE_LSB  = 9;         // One-hot state field
   localparam int          RUN_BIT    = 8;         // Run control echo
   localparam int          BRAKE_BIT  = 7;         // Brake control echo
   localparam int          DIR_BIT    = 6;         // Direction echo
   localparam int          SEL_BIT    = 5;         // Speed source echo
   localparam int          CFG_SEL    = 0;         // Speed source select
   localparam logic [15:0] CFG_RESET  = 16'h0000;  // Electrical cycle

   // ----------------------------------------------------------------
   // Commutation_rate_signal timing
   // ----------------------------------------------------------------
   localparam int          PERIOD_W   = 16;        // Period counter bits

   // ----------------------------------------------------------------
   // Sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_1 = 6'h01,
      ST_2 = 6'h02,
      ST_3 = 6'h04,
      ST_4 = 6'h08,
      ST_5 = 6'h10,
      ST_6 = 6'h20
   } bcs_state_e;

   // Next state in the chosen direction; 1 steps backwards
   function automatic bcs_state_e bcs_step(input bcs_state_e s,
                                           input logic       rev);
      bcs_state_e r;
      r = ST_1;
      case (s)
         ST_1:    r = rev ? ST_6 : ST_2;
         ST_2:    r = rev ? ST_1 : ST_3;
         ST_3:    r = rev ? ST_2 : ST_4;
         ST_4:    r = rev ? ST_3 : ST_5;
         ST_5:    r = rev ? ST_4 : ST_6;
         ST_6:    r = rev ? ST_5 : ST_1;
         default: r = ST_1;
      endcase
      return r;
   endfunction

   // Switch-on pattern {upper C,B,A, lower C,B,A}, 1 = switch on
   function automatic logic [5:0] bcs_drive(input bcs_state_e s);
      logic [5:0] d;
      d = 6'h00;
      case (s)
         ST_1:    d = 6'h0C;   // A high, C low
         ST_2:    d = 6'h14;   // B high, C low
         ST_3:    d = 6'h11;   // B high, A low
         ST_4:    d = 6'h21;   // C high, A low
         ST_5:    d = 6'h22;   // C high, B low
         ST_6:    d = 6'h0A;   // A high, B low
         default: d = 6'h00;
      endcase
      return d;
   endfunction

endpackage

// ---- verilog/bcs_link_if.sv ----
`timescale 1ns/1ps
// Words passed between the core and the serial port domain
interface bcs_link_if;
   logic [15:0] diag_word;   // Held stable by core while strobe is low
   logic [15:0] rx_word;     // Last complete word, written on the same edge as toggle
   logic        rx_toggle;   // Flips once per complete word

   modport core (output diag_word, input rx_word, input rx_toggle);
   modport port (input diag_word, output rx_word, output rx_toggle);
endinterface

// ---- verilog/bcs_serial_port.sv ----
`timescale 1ns/1ps
// Serial port logic, clocked by the host's serial clock
module bcs_serial_port
   import bcs_pkg::*;
(
   input  wire logic serial_clk_in,           // Serial clock from host
   input  wire logic nrst_in,                 // Async reset, active low
   input  wire logic serial_strobe_low_in,    // Strobe, active low
   input  wire logic serial_data_in,          // Serial data in
   output logic      serial_data_out,         // Serial data out value
   output logic      serial_data_oe_n_out,    // Low while driving
   bcs_link_if.port  link                     // Words to and from core
);

   // ----------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------
   wire        frame_rst_n = nrst_in & ~serial_strobe_low_in; // Frame end
   logic [3:0] bit_count;     // Rising edges seen in this frame
   logic [14:0] rx_shift;     // Bits received so far
   logic       tx_bit;        // Bit launched on last falling edge
   logic       tx_started;    // A falling edge has occurred
   wire        word_end = !serial_strobe_low_in && bit_count == LAST_BIT;

   // Receive shifter; a high strobe holds it cleared, so the clock
   // is ignored between frames
   // RL15: sample on rise
   always_ff @(posedge serial_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_count <= 4'h0;
         rx_shift  <= 15'h0000;
      end else begin
         bit_count <= bit_count + 4'h1;
         rx_shift  <= {rx_shift[13:0], serial_data_in};
      end
   end

   // Word handover; survives the frame end so the core can fetch it
   // RL13: msb first word
   always_ff @(posedge serial_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.rx_word   <= 16'h0000;
         link.rx_toggle <= 1'b0;
      end else if (word_end) begin
         link.rx_word   <= {rx_shift, serial_data_in};
         link.rx_toggle <= ~link.rx_toggle;
      end
   end

   // RL18: launch on fall
   always_ff @(negedge serial_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_bit     <= 1'b0;
         tx_started <= 1'b0;
      end else begin
         tx_bit     <= link.diag_word[LAST_BIT - bit_count];
         tx_started <= 1'b1;
      end
   end

   // RL14: fault bit first
   assign serial_data_out      = tx_started ? tx_bit
                                            : link.diag_word[FAULT_BIT];
   // RL14: released when idle
   assign serial_data_oe_n_out = serial_strobe_low_in;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   bit_wrap_a: assert property (@(posedge serial_clk_in) // RL13
      disable iff (!frame_rst_n)
      bit_count == LAST_BIT |=> bit_count == 4'h0)
      else $error("bit counter did not wrap after 16 bits");

   idle_quiet_a: assert property (@(posedge serial_clk_in) // RL17
      disable iff (!nrst_in)
      serial_strobe_low_in |=> $stable(link.rx_toggle))
      else $error("word accepted while strobe high");

endmodule

// ---- dv/bcs_bridge_model.sv ----
`timescale 1ns/1ps
// -------------------------------------------------------------------
// Three-phase bridge of P upper and N lower switches
// -------------------------------------------------------------------
module bcs_bridge_model (
   input  wire logic [2:0] upper_in,  // Upper gates {c,b,a}
   input  wire logic [2:0] lower_in,  // Lower gates {c,b,a}
   output logic      [5:0] phase_out  // Per phase 1 high, 2 low, 0 float
);
   // Both switches on shows as 3, so a shoot-through never passes
   // for a legal phase pattern; an unknown gate counts as off
   // gate polarity
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         phase_out[2*i +: 2] = {lower_in[i] === 1'b1, upper_in[i] === 1'b0};
      end
   end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import bcs_pkg::*;
   // ---------------------------------------------------------------
   // Signals and expectation notes
   // ---------------------------------------------------------------
   typedef struct {int k; logic [15:0] v; logic [15:0] m;} bcs_note_s;
   bcs_note_s   notes[$];       // Expected results, oldest first
   bcs_note_s   n;              // Note under comparison
   event        look;           // Outputs settled, compare now
   int          errors, tests_run, seed, idx;
   logic        clk, sclk, nrst, run, brake_control, dir, pulse, load, fault;
   logic        strb_n, sdi, sdo, sdo_oe_n, speed_output, spd_oe_n, flt, flt_oe_n;
   logic [2:0]  up, lo;         // Gate pins {c,b,a}
   logic [5:0]  lst, st, phase; // Load state, state, bridge phases
   logic [15:0] cfg, w;         // Config word, word sent
   // Phases {C,B,A} of states 1..6 as the bridge shows them
   logic [5:0]  ph_tab [6] = '{6'h21, 6'h24, 6'h06, 6'h12, 6'h18, 6'h09};

   bcs_sequencer bcs_sequencer_i (
      .sys_clk_in(clk), .nrst_in(nrst), .run_in(run),
      .brake_control_in(brake_control), .direction_in(dir),
      .commutation_pulse_in(pulse), .load_in(load), .load_state_in(lst),
      .fault_flag_in(fault), .serial_clk_in(sclk),
      .serial_strobe_low_in(strb_n), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_oe_n_out(sdo_oe_n),
      .upper_gate_a_out(up[0]), .upper_gate_b_out(up[1]),
      .upper_gate_c_out(up[2]), .lower_gate_a_out(lo[0]),
      .lower_gate_b_out(lo[1]), .lower_gate_c_out(lo[2]),
      .speed_output_out(speed_output), .speed_output_oe_n_out(spd_oe_n),
      .fault_output_low_out(flt), .fault_output_low_oe_n_out(flt_oe_n),
      .config_word_out(cfg), .state_out(st));
   bcs_bridge_model bcs_bridge_model_i (
      .upper_in(up), .lower_in(lo), .phase_out(phase));

   // ---------------------------------------------------------------
   // Clock, compare tasks and monitor
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Sync notes wait for the falling edge so registered outputs settle
   task automatic note(input int k, input logic [15:0] v,
                       input logic [15:0] m, input bit sync);
      if (sync) @(negedge clk);
      notes.push_back('{k, v, m});
      -> look;
   endtask
   task automatic cmp(input logic [15:0] o, input bcs_note_s e);
      tests_run++;
      if ((o & e.m) !== (e.v & e.m)) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, o & e.m, e.v & e.m);
      end
   endtask
   task automatic cmp_drv(input bcs_note_s e);
      cmp({4'h0, st, phase}, e);
   endtask
   task automatic cmp_cfg(input bcs_note_s e);
      cmp(cfg, e);
   endtask
   task automatic cmp_pin(input bcs_note_s e);
      cmp({10'h0, spd_oe_n, speed_output, flt_oe_n, flt, sdo_oe_n, sdo}, e);
   endtask
   // Takes the oldest note each time a result is announced
   initial forever begin
      @(look);
      n = notes.pop_front();
      case (n.k)
         0:       cmp_drv(n);
         1:       cmp_cfg(n);
         default: cmp_pin(n);
      endcase
   end
   task automatic chk_drv(input int i, input logic [5:0] p);
      note(0, {4'h0, 6'h01 << i, p}, 16'hFFFF, 1'b1);
   endtask
   // Pin bits {spd_oe_n, spd, flt_oe_n, flt, sdo_oe_n, sdo}
   task automatic chk_pin(input logic [5:0] v, input logic [5:0] m,
                          input bit s);
      note(2, {10'h0, v}, {10'h0, m}, s);
   endtask

   // ---------------------------------------------------------------
   // Stimulus tasks
   // ---------------------------------------------------------------
   task automatic ctl(input logic r, input logic b, input logic d);
      @(posedge clk) begin
         run <= r;
         brake_control <= b;
         dir <= d;
      end
      @(posedge clk);
   endtask
   task automatic pulses(input int k);
      @(posedge clk) pulse <= 1'b1;
      repeat (k) @(posedge clk);
      pulse <= 1'b0;
   endtask
   // A pulse rides along with the load; the load has to win
   task automatic ld(input int i);
      @(posedge clk) begin
         load <= 1'b1;
         pulse <= 1'b1;
         lst <= 6'h01 << i;
      end
      @(posedge clk) begin
         load <= 1'b0;
         pulse <= 1'b0;
      end
      @(posedge clk);
   endtask
   // Seven pulses back to back so every step and the wrap are seen
   task automatic burst(input logic d, input int s);
      @(posedge clk) begin
         dir <= d;
         pulse <= 1'b1;
      end
      for (int i = 1; i <= 7; i++) begin
         @(posedge clk);
         if (i == 7) pulse <= 1'b0;
         idx = d ? (s - i + 12) % 6 : (s + i) % 6;
         chk_drv(idx, ph_tab[idx]);
      end
   endtask
   // Host frame; clock only runs inside it, offset from the system
   // clock; with sel low the strobe stays high and it must be ignored
   task automatic ser(input logic [15:0] x, input bit sel, input bit c);
      #3 strb_n = ~sel;
      #2 if (c) chk_pin(6'h01, 6'h03, 1'b0);
      repeat (4) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         #7.5 sclk = 1'b0;
         sdi = x[i];
         #2 if (c && (i == 14 || i == 9))
            chk_pin({5'h00, i == 9}, 6'h03, 1'b0);
         #5.5 sclk = 1'b1;
      end
      #7.5 strb_n = 1'b1;
      sdi = ~sdi;
      #2 chk_pin(6'h02, 6'h02, 1'b0);
      repeat (8) @(posedge clk);
   endtask

   // ---------------------------------------------------------------
   // Main sequence, watchdog and verdict
   // ---------------------------------------------------------------
   task automatic summarize();
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      summarize();
   end
   initial begin
      seed = 8;
      errors = 0;
      tests_run = 0;
      {run, brake_control, dir, pulse, load, fault, sdi} = 7'h00;
      {sclk, strb_n} = 2'h3;
      lst = 6'h01;
      nrst = 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk_drv(0, 6'h00);
      ctl(1'b1, 1'b0, 1'b0);
      chk_drv(0, ph_tab[0]);
      burst(1'b0, 0);
      burst(1'b1, 1);
      ctl(1'b1, 1'b1, 1'b0);
      pulses(2);
      chk_drv(0, 6'h2A);
      ctl(1'b0, 1'b1, 1'b1);
      pulses(2);
      chk_drv(0, 6'h00);
      ctl(1'b1, 1'b0, 1'b0);
      for (int j = 0; j < 4; j++) begin
         idx = {$random(seed)} % 6;
         ld(idx);
         chk_drv(idx, ph_tab[idx]);
      end
      ld(3);
      chk_pin(6'h00, 6'h30, 1'b1);
      ld(0);
      chk_pin(6'h20, 6'h30, 1'b1);
      @(posedge clk) fault <= 1'b1;
      @(posedge clk);
      chk_pin(6'h00, 6'h0C, 1'b1);
      w = 16'($random(seed)) & 16'hFFFE;
      ser(w, 1'b1, 1'b1);
      note(1, w, 16'hFFFF, 1'b1);
      @(posedge clk) fault <= 1'b0;
      @(posedge clk);
      chk_pin(6'h08, 6'h0C, 1'b1);
      w = 16'($random(seed)) | 16'h0001;
      ser(w, 1'b1, 1'b0);
      note(1, w, 16'hFFFF, 1'b1);
      pulses(1);
      repeat (40) @(posedge clk);
      pulses(1);
      repeat (40) @(posedge clk);
      chk_pin(6'h20, 6'h30, 1'b1);
      pulses(1);
      repeat (2) @(posedge clk);
      chk_pin(6'h00, 6'h30, 1'b1);
      ser(~w, 1'b0, 1'b0);
      note(1, w, 16'hFFFF, 1'b1);
      @(posedge clk);
      summarize();
   end
endmodule
